// file: usb_glue_defs.vh
// register map, field positions, keys and timing for the usb glue block
`ifndef USB_GLUE_DEFS_VH
`define USB_GLUE_DEFS_VH

`define UG_ADDR_W 16
`define UG_DATA_W 16

// register offsets
`define UG_PIN_OFS 16'h4044
`define UG_EN0_OFS 16'h4046
`define UG_EN1_OFS 16'h4048
`define UG_STS0_OFS 16'h404a
`define UG_STS1_OFS 16'h404c
`define UG_MSK0_OFS 16'h404e
`define UG_MSK1_OFS 16'h4050
`define UG_RSTKEY_OFS 16'h4052
`define UG_WAIT_OFS 16'h4054

// field positions
`define UG_PULLUP_BIT 0
`define UG_DETECT_BIT 1
`define UG_CONN_BIT 6
`define UG_PRST_BIT 1
`define UG_DISC_BIT 6
`define UG_CFG_BIT 4
`define UG_CORE_BIT 0

// writable bits per bank; all others reserved and read zero
`define UG_BANK0_MASK 16'h0042
`define UG_BANK1_MASK 16'h0051

// reset values
`define UG_REG_RST 16'h0000
`define UG_WAIT_RST 2'h1

// module reset key and pulse length
`define UG_RST_KEY 8'ha4
`define UG_SWRST_CYC 4'h8

// cable detect settle time
`define UG_CLK_HZ 250000000
`define UG_SETTLE_MS 500

`endif

// file: edge_detect.v
// sticky edge detector with write-one-to-clear
module edge_detect #(
   parameter RISING = 1
) (
   // clock and reset
   input wire i_ref_clk,
   input wire i_nrst,
   // event source and clear
   input wire i_src,
   input wire i_clr,
   // sticky flag
   output wire o_flag
);
   reg src_q;
   reg flag_q;
   wire hit;

   assign hit = RISING ? (i_src & ~src_q) : (~i_src & src_q);
   assign o_flag = flag_q;

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         src_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         src_q <= i_src;
         // set wins over a clear in the same cycle
         if (hit)
            flag_q <= 1'b1;
         else if (i_clr)
            flag_q <= 1'b0;
      end
   end
endmodule // edge_detect

// file: usb_glue_interrupt_control.v
// usb support logic: pin status, pull-up, interrupt banks, module reset, wait states
//
// Functional notes
// - detect bit shows pin after 0.5 s steady
// - pull-up pin follows pin register bit 0
// - enable bit 1 passes, 0 masks status
// - bank0 latches rising connect and port reset
// - bank1 latches falling disconnect, configured, core irq
// - writing one clears status bit
// - port reset source: module soft reset or usb reset
// - configured and disconnect sources from core
// - core irq source from core registers
// - masked registers read status and enable
// - only key a4 resets usb module
// - two-bit wait-state field sets internal waits
//
// Local design decision: the strobed register port.
`include "usb_glue_defs.vh"

module usb_glue_interrupt_control #(
   parameter SETTLE_CYC = (`UG_CLK_HZ / 1000) * `UG_SETTLE_MS
) (
   // clock and reset
   input wire i_ref_clk,
   input wire i_nrst,
   // register port
   input wire [`UG_ADDR_W-1:0] i_addr,
   input wire [`UG_DATA_W-1:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [`UG_DATA_W-1:0] o_rdata,
   // pins
   input wire i_cable_detect_in,
   output wire o_pullup_ctrl_out,
   // usb core event sources
   input wire i_core_connected,
   input wire i_core_port_reset,
   input wire i_core_configured,
   input wire i_core_irq,
   // module reset and wait states toward the core
   output wire o_usb_soft_rst,
   output wire [1:0] o_wait_states,
   // interrupt
   output wire o_usb_irq
);
   // detect pin synchroniser and settle filter
   reg det_s1_q;
   reg det_s2_q;
   reg det_stable_q;
   reg [31:0] settle_cnt_q;

   reg pullup_q;
   reg [`UG_DATA_W-1:0] en0_q;
   reg [`UG_DATA_W-1:0] en1_q;
   reg [1:0] wait_q;
   reg [3:0] swrst_cnt_q;

   wire [`UG_DATA_W-1:0] sts0;
   wire [`UG_DATA_W-1:0] sts1;
   wire [`UG_DATA_W-1:0] msk0;
   wire [`UG_DATA_W-1:0] msk1;
   wire wr_sts0;
   wire wr_sts1;
   wire port_reset_event;
   wire sync_core_conn;
   wire sync_core_prst;
   wire sync_core_cfg;
   wire sync_core_irq;
   // one flag per documented event; every other status bit stays zero
   wire flag_conn;
   wire flag_prst;
   wire flag_disc;
   wire flag_cfg;
   wire flag_irq;
   wire [`UG_DATA_W-1:0] pin_word;

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         det_s1_q <= 1'b0;
         det_s2_q <= 1'b0;
         det_stable_q <= 1'b0;
         settle_cnt_q <= 32'h0;
      end else begin
         det_s1_q <= i_cable_detect_in;
         det_s2_q <= det_s1_q;
         // any bounce restarts the full settle period
         if (det_s2_q == det_stable_q)
            settle_cnt_q <= 32'h0;
         else if (settle_cnt_q >= SETTLE_CYC - 1) begin
            det_stable_q <= det_s2_q;
            settle_cnt_q <= 32'h0;
         end else
            settle_cnt_q <= settle_cnt_q + 32'h1;
      end
   end

   // core sources are on this clock already
   assign sync_core_conn = i_core_connected;
   assign sync_core_cfg = i_core_configured;
   assign sync_core_irq = i_core_irq;
   // module soft reset also counts as a usb reset
   assign sync_core_prst = i_core_port_reset;
   assign port_reset_event = sync_core_prst | o_usb_soft_rst;

   assign wr_sts0 = i_wr && (i_addr == `UG_STS0_OFS);
   assign wr_sts1 = i_wr && (i_addr == `UG_STS1_OFS);

   // bank 0: rising edges
   edge_detect #(.RISING(1)) u_conn (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_src(sync_core_conn),
      .i_clr(wr_sts0 & i_wdata[`UG_CONN_BIT]),
      .o_flag(flag_conn)
   );
   edge_detect #(.RISING(1)) u_prst (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_src(port_reset_event),
      .i_clr(wr_sts0 & i_wdata[`UG_PRST_BIT]),
      .o_flag(flag_prst)
   );
   // bank 1: falling edges
   edge_detect #(.RISING(0)) u_disc (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_src(sync_core_conn),
      .i_clr(wr_sts1 & i_wdata[`UG_DISC_BIT]),
      .o_flag(flag_disc)
   );
   edge_detect #(.RISING(0)) u_cfg (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_src(sync_core_cfg),
      .i_clr(wr_sts1 & i_wdata[`UG_CFG_BIT]),
      .o_flag(flag_cfg)
   );
   edge_detect #(.RISING(0)) u_irq (
      .i_ref_clk(i_ref_clk),
      .i_nrst(i_nrst),
      .i_src(sync_core_irq),
      .i_clr(wr_sts1 & i_wdata[`UG_CORE_BIT]),
      .o_flag(flag_irq)
   );

   // reserved status bits are constant zero
   assign sts0 = ({{(`UG_DATA_W-1){1'b0}}, flag_conn} << `UG_CONN_BIT)
      | ({{(`UG_DATA_W-1){1'b0}}, flag_prst} << `UG_PRST_BIT);
   assign sts1 = ({{(`UG_DATA_W-1){1'b0}}, flag_disc} << `UG_DISC_BIT)
      | ({{(`UG_DATA_W-1){1'b0}}, flag_cfg} << `UG_CFG_BIT)
      | ({{(`UG_DATA_W-1){1'b0}}, flag_irq} << `UG_CORE_BIT);
   // detect bit is read only; writes to it are dropped
   assign pin_word = ({{(`UG_DATA_W-1){1'b0}}, det_stable_q} << `UG_DETECT_BIT)
      | ({{(`UG_DATA_W-1){1'b0}}, pullup_q} << `UG_PULLUP_BIT);

   assign msk0 = sts0 & en0_q;
   assign msk1 = sts1 & en1_q;
   assign o_usb_irq = |{msk0, msk1};

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         pullup_q <= 1'b0;
         en0_q <= `UG_REG_RST;
         en1_q <= `UG_REG_RST;
         wait_q <= `UG_WAIT_RST;
         swrst_cnt_q <= 4'h0;
      end else begin
         if (swrst_cnt_q != 4'h0)
            swrst_cnt_q <= swrst_cnt_q - 4'h1;
         if (i_wr) begin
            case (i_addr)
               `UG_PIN_OFS: pullup_q <= i_wdata[`UG_PULLUP_BIT];
               `UG_EN0_OFS: en0_q <= i_wdata & `UG_BANK0_MASK;
               `UG_EN1_OFS: en1_q <= i_wdata & `UG_BANK1_MASK;
               `UG_WAIT_OFS: wait_q <= i_wdata[1:0];
               `UG_RSTKEY_OFS: begin
                  // any other pattern is dropped silently
                  if (i_wdata[7:0] == `UG_RST_KEY)
                     swrst_cnt_q <= `UG_SWRST_CYC;
               end
               default: ;
            endcase
         end
      end
   end

   assign o_pullup_ctrl_out = pullup_q;
   assign o_usb_soft_rst = (swrst_cnt_q != 4'h0);
   assign o_wait_states = wait_q;

   // read data valid the cycle after the strobe only
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst)
         o_rdata <= `UG_REG_RST;
      else if (i_rd) begin
         case (i_addr)
            `UG_PIN_OFS: o_rdata <= pin_word;
            `UG_EN0_OFS: o_rdata <= en0_q;
            `UG_EN1_OFS: o_rdata <= en1_q;
            `UG_STS0_OFS: o_rdata <= sts0;
            `UG_STS1_OFS: o_rdata <= sts1;
            `UG_MSK0_OFS: o_rdata <= msk0;
            `UG_MSK1_OFS: o_rdata <= msk1;
            `UG_WAIT_OFS: o_rdata <= {14'h0, wait_q};
            `UG_RSTKEY_OFS: o_rdata <= `UG_REG_RST;
            default: o_rdata <= `UG_REG_RST;
         endcase
      end else
         o_rdata <= `UG_REG_RST;
   end
endmodule // usb_glue_interrupt_control

// file: usb_glue_chk.sv
// port assertions for the usb glue block
module usb_glue_chk (
   // clock and reset
   input logic i_ref_clk,
   input logic i_nrst,
   // register port
   input logic [15:0] i_addr,
   input logic [15:0] i_wdata,
   input logic i_wr,
   input logic i_rd,
   input logic [15:0] o_rdata,
   // pins
   input logic i_cable_detect_in,
   input logic o_pullup_ctrl_out,
   // core event sources
   input logic i_core_connected,
   input logic i_core_port_reset,
   input logic i_core_configured,
   input logic i_core_irq,
   // reset, wait states, interrupt
   input logic o_usb_soft_rst,
   input logic [1:0] o_wait_states,
   input logic o_usb_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   logic [15:0] wd_q;
   logic key_q, wr_q;
   logic [2:0] ev_q;
   // three-cycle window covers the soft reset counter flop and the flag flop
   always_ff @(posedge i_ref_clk) begin
      wd_q <= i_wdata;
      wr_q <= i_wr;
      key_q <= i_wr && i_addr == 16'h4052 && i_wdata[7:0] == 8'ha4;
      ev_q <= {ev_q[1:0], i_wr || $changed({i_core_connected, i_core_port_reset, i_core_configured, i_core_irq,
         o_usb_soft_rst})};
   end
   chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000) else $error("read data not idle");
   chk_key_read: assert property (i_rd && i_addr == 16'h4052 |=> o_rdata == 16'h0000) else $error("key read");
   chk_key_pulse: assert property (i_wr && i_addr == 16'h4052 && i_wdata[7:0] == 8'ha4
      |=> o_usb_soft_rst [*8]) else $error("reset pulse short");
   chk_rst_cause: assert property ($rose(o_usb_soft_rst) |-> key_q) else $error("reset without key");
   chk_pull_wr: assert property (i_wr && i_addr == 16'h4044 |=> o_pullup_ctrl_out == wd_q[0])
      else $error("pull-up not written");
   chk_pull_hold: assert property (!(i_wr && i_addr == 16'h4044) |=> $stable(o_pullup_ctrl_out))
      else $error("pull-up moved");
   chk_wait_wr: assert property (i_wr && i_addr == 16'h4054 |=> o_wait_states == wd_q[1:0])
      else $error("wait states not written");
   chk_irq_rise: assert property ($rose(o_usb_irq) |-> |ev_q) else $error("irq without cause");
   chk_irq_fall: assert property ($fell(o_usb_irq) |-> wr_q) else $error("irq dropped without write");
endmodule // usb_glue_chk
bind usb_glue_interrupt_control usb_glue_chk chk_i (.*);

// file: usb_core_model.sv
// behavioural usb core: event source levels and cable pin
module usb_core_model (
   // clock
   input logic i_ref_clk,
   // event source levels and cable pin
   output logic [3:0] o_src,
   output logic o_det
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_src = 4'h0;
      o_det = 1'b0;
   end
   // order: connected, port reset, configured, core irq
   task drive(input logic [3:0] s, input logic d);
      @(posedge i_ref_clk);
      o_src <= s;
      o_det <= d;
   endtask
endmodule // usb_core_model

// file: usb_glue_interrupt_control_bench.sv
// register-level bench for the usb glue block
module usb_glue_interrupt_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, nrst = 0, wr_s = 0, rd_s = 0;
   logic [15:0] addr = 16'h0000, wdata = 16'h0000;
   wire [15:0] rdata;
   wire [3:0] src;
   wire det, pup, srst, irq;
   wire [1:0] ws;
   int errors = 0, n_compared = 0;
   always #2 clk = ~clk;
   usb_core_model core(.i_ref_clk(clk), .o_src(src), .o_det(det));
   usb_glue_interrupt_control #(.SETTLE_CYC(20)) uut(.i_ref_clk(clk), .i_nrst(nrst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_cable_detect_in(det),
      .o_pullup_ctrl_out(pup), .i_core_connected(src[3]), .i_core_port_reset(src[2]),
      .i_core_configured(src[1]), .i_core_irq(src[0]), .o_usb_soft_rst(srst), .o_wait_states(ws), .o_usb_irq(irq));
   task chk(input logic [15:0] s, e);
      n_compared++;
      if (s !== e) begin
         $display("[FAIL] %0t seen %h exp %h", $time, s, e);
         errors++;
      end
   endtask
   task wr(input logic [15:0] a, d);
      @(posedge clk);
      wr_s <= 1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 0;
      #1;
   endtask
   task rd(input logic [15:0] a, e);
      @(posedge clk);
      rd_s <= 1;
      addr <= a;
      @(posedge clk);
      rd_s <= 0;
      #1;
      chk(rdata, e);
   endtask
   task finish_test;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000;
      errors++;
      finish_test;
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1;
      chk({14'h0, ws}, 16'h0001);
      for (int a = 16'h4044; a <= 16'h4056; a += 2) rd(a[15:0], a == 16'h4054 ? 16'h0001 : 16'h0000);
      $display("test reset done");
      wr(16'h404a, 16'hffff);
      wr(16'h404c, 16'hffff);
      wr(16'h4046, 16'hffff);
      wr(16'h4048, 16'hffff);
      rd(16'h4046, 16'h0042);
      rd(16'h4048, 16'h0051);
      core.drive(4'hf, 0);
      repeat (3) @(posedge clk);
      rd(16'h404a, 16'h0042);
      rd(16'h404c, 16'h0000);
      core.drive(4'h0, 0);
      repeat (3) @(posedge clk);
      rd(16'h404c, 16'h0051);
      rd(16'h4050, 16'h0051);
      rd(16'h404e, 16'h0042);
      chk({15'h0, irq}, 16'h0001);
      wr(16'h4046, 16'h0000);
      rd(16'h404e, 16'h0000);
      wr(16'h4048, 16'h0010);
      rd(16'h4050, 16'h0010);
      chk({15'h0, irq}, 16'h0001);
      wr(16'h404c, 16'h0010);
      chk({15'h0, irq}, 16'h0000);
      rd(16'h404c, 16'h0041);
      wr(16'h404a, 16'h0000);
      rd(16'h404a, 16'h0042);
      wr(16'h404a, 16'h0040);
      rd(16'h404a, 16'h0002);
      wr(16'h404a, 16'hffff);
      rd(16'h404a, 16'h0000);
      $display("test events done");
      wr(16'h4052, 16'h00a5);
      chk({15'h0, srst}, 16'h0000);
      wr(16'h4052, 16'h00a4);
      chk({15'h0, srst}, 16'h0001);
      rd(16'h4052, 16'h0000);
      repeat (10) @(posedge clk);
      rd(16'h404a, 16'h0002);
      wr(16'h4054, 16'h0002);
      chk({14'h0, ws}, 16'h0002);
      wr(16'h4054, 16'h0001);
      wr(16'h4044, 16'h0001);
      chk({15'h0, pup}, 16'h0001);
      core.drive(4'h0, 1);
      repeat (10) @(posedge clk);
      rd(16'h4044, 16'h0001);
      repeat (20) @(posedge clk);
      rd(16'h4044, 16'h0003);
      $display("test pins done");
      finish_test;
   end
endmodule // usb_glue_interrupt_control_bench
